/* File: logic/sqc_pkg.sv */
// Shared constants and types of the sequence pattern error checker
package sqc_pkg;
  localparam int unsigned SQC_MAX_BLOCKS = 128;
  localparam int unsigned SQC_BLK_W      = 7;
  localparam int unsigned SQC_LEN_W      = 16;
  localparam int unsigned SQC_PAT_W      = 64;
  localparam int unsigned SQC_ROUTES     = 32;
  localparam int unsigned SQC_ROUTE_W    = 5;
  localparam int unsigned SQC_MLEN_W     = 4;
  localparam int unsigned SQC_MLEN_STEP  = 4;
  localparam int unsigned SQC_ADDR_W     = 8;

  // Register byte offsets
  localparam logic [7:0] SQC_CTRL_OFF     = 8'h00;
  localparam logic [7:0] SQC_STATUS_OFF   = 8'h04;
  localparam logic [7:0] SQC_NBLK_OFF     = 8'h08;
  localparam logic [7:0] SQC_ERRCNT_OFF   = 8'h0c;
  localparam logic [7:0] SQC_BITCNT_OFF   = 8'h10;
  localparam logic [7:0] SQC_BWMASK_OFF   = 8'h14;
  localparam logic [7:0] SQC_RTMASK_OFF   = 8'h18;
  localparam logic [7:0] SQC_PATA_LO_OFF  = 8'h1c;
  localparam logic [7:0] SQC_PATA_HI_OFF  = 8'h20;
  localparam logic [7:0] SQC_MSKA_LO_OFF  = 8'h24;
  localparam logic [7:0] SQC_MSKA_HI_OFF  = 8'h28;
  localparam logic [7:0] SQC_PATB_LO_OFF  = 8'h2c;
  localparam logic [7:0] SQC_PATB_HI_OFF  = 8'h30;
  localparam logic [7:0] SQC_MSKB_LO_OFF  = 8'h34;
  localparam logic [7:0] SQC_MSKB_HI_OFF  = 8'h38;
  localparam logic [7:0] SQC_BLKIDX_OFF   = 8'h3c;
  localparam logic [7:0] SQC_BLKDATA_OFF  = 8'h40;
  localparam logic [7:0] SQC_BLKCFG_OFF   = 8'h44;
  localparam logic [7:0] SQC_IRQSTAT_OFF  = 8'h48;
  localparam logic [7:0] SQC_IRQEN_OFF    = 8'h4c;
  localparam logic [7:0] SQC_IRQCLR_OFF   = 8'h50;

  // Control register fields
  localparam int unsigned SQC_C_SEQ_EN    = 0;
  localparam int unsigned SQC_C_HIZ       = 1;
  localparam int unsigned SQC_C_MERGE     = 2;
  localparam int unsigned SQC_C_BURST     = 3;
  localparam int unsigned SQC_C_BWIN_EN   = 4;
  localparam int unsigned SQC_C_RTMASK_EN = 5;
  localparam int unsigned SQC_C_EXT_EN    = 6;
  localparam int unsigned SQC_C_AUX_EXT   = 7;
  localparam int unsigned SQC_C_KIND_LO   = 8;
  localparam int unsigned SQC_CTRL_W      = 10;
  localparam logic [9:0]  SQC_CTRL_RST    = 10'h000;

  // Block configuration word fields
  localparam int unsigned SQC_CFG_SEL     = 16;
  localparam int unsigned SQC_CFG_MLEN_LO = 20;

  // Pattern kinds
  localparam logic [1:0] SQC_KIND_DATA  = 2'h0;
  localparam logic [1:0] SQC_KIND_PRBS  = 2'h1;
  localparam logic [1:0] SQC_KIND_MIXED = 2'h2;

  // Interrupt status bits
  localparam int unsigned SQC_I_SYNC    = 0;
  localparam int unsigned SQC_I_LOSS    = 1;
  localparam int unsigned SQC_I_ERROR   = 2;
  localparam int unsigned SQC_I_REFUSED = 3;
  localparam int unsigned SQC_IRQ_W     = 4;

  localparam logic [6:0]  SQC_NBLK_RST = 7'h00;
  localparam logic [1:0]  SQC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SQC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SQC_IDLE, SQC_HUNT, SQC_CHECK} sqc_state_t;
endpackage

/* File: logic/sqc_match.sv */
// Masked, length-limited comparator of the alignment match pattern
`timescale 1ns/1ns
module sqc_match
  import sqc_pkg::*;
(
  input  wire logic [SQC_PAT_W-1:0]  window,   // Newest bit in bit 0
  input  wire logic [SQC_PAT_W-1:0]  pattern,  // Match pattern
  input  wire logic [SQC_PAT_W-1:0]  mask,     // 1 = bit ignored
  input  wire logic [SQC_MLEN_W-1:0] len_code, // Length/4 minus one
  output logic                       hit       // Window matches
);
  import sqc_pkg::*;

  logic [SQC_PAT_W-1:0] diff;
  logic [6:0]           nbits;

  always_comb begin
    nbits = 7'((32'(len_code) + 32'd1) * SQC_MLEN_STEP);
    diff  = '0;
    for (int i = 0; i < SQC_PAT_W; i++) begin
      if (7'(i) < nbits && !mask[i]) begin
        diff[i] = window[i] ^ pattern[i];
      end
    end
    hit = (diff == '0);
  end
endmodule

/* File: logic/sqc_checker.sv */
// Sequence pattern error checker with AXI4-Lite register access
//
// Notes on behaviour
// - Up to 127 blocks checked in order
// - Sequence mode refused under merge or burst
// - Polarity selects meaning of high level
// - Per-block match pattern from source A/B
// - Match length 4 to 64, 4-bit steps
// - Mask bit 1 excludes match position
// - Per-bit measurement mask when enabled
// - Bit mask: none for PRBS, segments mixed
// - 32 routes; masked routes not counted
// - External mask only if aux assigned
`timescale 1ns/1ns
module sqc_checker
  import sqc_pkg::*;
(
  input  wire logic                  aclk,        // 20 MHz clock
  input  wire logic                  aresetn,     // Sync reset, low
  input  wire logic                  rx_data,     // Serial data pin
  input  wire logic                  ext_mask_in, // External mask pin
  input  wire logic [SQC_ADDR_W-1:0] awaddr,      // Write address
  input  wire logic                  awvalid,     // Write addr valid
  output logic                       awready,     // Write addr ready
  input  wire logic [31:0]           wdata,       // Write data
  input  wire logic [3:0]            wstrb,       // Byte enables
  input  wire logic                  wvalid,      // Write data valid
  output logic                       wready,      // Write data ready
  output logic [1:0]                 bresp,       // Write response
  output logic                       bvalid,      // Response valid
  input  wire logic                  bready,      // Response ready
  input  wire logic [SQC_ADDR_W-1:0] araddr,      // Read address
  input  wire logic                  arvalid,     // Read addr valid
  output logic                       arready,     // Read addr ready
  output logic [31:0]                rdata,       // Read data
  output logic [1:0]                 rresp,       // Read response
  output logic                       rvalid,      // Read data valid
  input  wire logic                  rready,      // Read data ready
  output logic                       irq,         // Level interrupt
  output logic                       in_sync      // Block aligned
);
  import sqc_pkg::*;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic known_addr(input logic [SQC_ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= SQC_IRQCLR_OFF);
  endfunction

  // Bus slave state
  logic                  awready_reg, wready_reg, bvalid_reg, arready_reg;
  logic                  rvalid_reg, irq_reg, in_sync_reg;
  logic [1:0]            bresp_reg, rresp_reg;
  logic [31:0]           rdata_reg, wdata_reg;
  logic [3:0]            wstrb_reg;
  logic [SQC_ADDR_W-1:0] waddr_reg;
  logic                  wr_fire;

  // Software registers
  logic [SQC_CTRL_W-1:0] ctrl_reg;
  logic [SQC_BLK_W-1:0]  nblk_reg, blk_idx_reg;
  logic [31:0]           bwmask_reg, rtmask_reg, blk_data_reg;
  logic [31:0]           err_cnt_reg, bit_cnt_reg;
  logic [SQC_PAT_W-1:0]  pat_reg [2];
  logic [SQC_PAT_W-1:0]  msk_reg [2];
  logic [SQC_IRQ_W-1:0]  irq_stat_reg, irq_en_reg, irq_evt;

  // Block table
  logic [31:0]           blk_data_mem [SQC_MAX_BLOCKS];
  logic [SQC_LEN_W-1:0]  blk_len_mem  [SQC_MAX_BLOCKS];
  logic                  blk_sel_mem  [SQC_MAX_BLOCKS];
  logic [SQC_MLEN_W-1:0] blk_mlen_mem [SQC_MAX_BLOCKS];

  // Receive path
  logic                  rx_meta_reg, rx_sync_reg, ext_meta_reg, ext_sync_reg;
  logic [SQC_PAT_W-1:0]  win_reg, win_now;
  logic                  rx_bit, hit, seq_active, refused;
  sqc_state_t            state_reg;
  logic [SQC_BLK_W-1:0]  cur_blk_reg;
  logic [SQC_LEN_W-1:0]  pos_reg, hunt_reg, cur_len;
  logic [SQC_ROUTE_W-1:0] route;
  logic                  cur_sel, exp_bit, bw_ok, route_ok, ext_hold;
  logic                  counted, bit_err;
  logic [SQC_MLEN_W-1:0] cur_mlen;

  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;
  assign irq     = irq_reg;
  assign in_sync = in_sync_reg;

  // Write address and data are taken in either order
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= SQC_RESP_OKAY;
      waddr_reg   <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
    end else begin
      if (awvalid && awready_reg) begin
        awready_reg <= 1'b0;
        waddr_reg   <= awaddr;
      end
      if (wvalid && wready_reg) begin
        wready_reg <= 1'b0;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= known_addr(waddr_reg) ? SQC_RESP_OKAY
                                            : SQC_RESP_SLVERR;
      end
      if (bvalid_reg && bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Control and configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg     <= SQC_CTRL_RST;
      nblk_reg     <= SQC_NBLK_RST;
      bwmask_reg   <= '0;
      rtmask_reg   <= '0;
      blk_idx_reg  <= '0;
      blk_data_reg <= '0;
      irq_en_reg   <= '0;
      for (int k = 0; k < 2; k++) begin
        pat_reg[k] <= '0;
        msk_reg[k] <= '0;
      end
    end else if (wr_fire) begin
      case (waddr_reg)
        SQC_CTRL_OFF:    ctrl_reg <= SQC_CTRL_W'(merge_strb(
                           32'(ctrl_reg), wdata_reg, wstrb_reg));
        SQC_NBLK_OFF:    nblk_reg <= SQC_BLK_W'(merge_strb(
                           32'(nblk_reg), wdata_reg, wstrb_reg));
        SQC_BWMASK_OFF:  bwmask_reg <= merge_strb(bwmask_reg, wdata_reg,
                                                  wstrb_reg);
        SQC_RTMASK_OFF:  rtmask_reg <= merge_strb(rtmask_reg, wdata_reg,
                                                  wstrb_reg);
        SQC_PATA_LO_OFF: pat_reg[0][31:0] <= merge_strb(pat_reg[0][31:0],
                           wdata_reg, wstrb_reg);
        SQC_PATA_HI_OFF: pat_reg[0][63:32] <= merge_strb(pat_reg[0][63:32],
                           wdata_reg, wstrb_reg);
        SQC_MSKA_LO_OFF: msk_reg[0][31:0] <= merge_strb(msk_reg[0][31:0],
                           wdata_reg, wstrb_reg);
        SQC_MSKA_HI_OFF: msk_reg[0][63:32] <= merge_strb(msk_reg[0][63:32],
                           wdata_reg, wstrb_reg);
        SQC_PATB_LO_OFF: pat_reg[1][31:0] <= merge_strb(pat_reg[1][31:0],
                           wdata_reg, wstrb_reg);
        SQC_PATB_HI_OFF: pat_reg[1][63:32] <= merge_strb(pat_reg[1][63:32],
                           wdata_reg, wstrb_reg);
        SQC_MSKB_LO_OFF: msk_reg[1][31:0] <= merge_strb(msk_reg[1][31:0],
                           wdata_reg, wstrb_reg);
        SQC_MSKB_HI_OFF: msk_reg[1][63:32] <= merge_strb(msk_reg[1][63:32],
                           wdata_reg, wstrb_reg);
        SQC_BLKIDX_OFF:  blk_idx_reg <= SQC_BLK_W'(merge_strb(
                           32'(blk_idx_reg), wdata_reg, wstrb_reg));
        SQC_BLKDATA_OFF: blk_data_reg <= merge_strb(blk_data_reg, wdata_reg,
                                                    wstrb_reg);
        SQC_IRQEN_OFF:   irq_en_reg <= SQC_IRQ_W'(merge_strb(
                           32'(irq_en_reg), wdata_reg, wstrb_reg));
        default: begin
        end
      endcase
    end
  end

  // Writing the block config word commits the whole table entry
  always_ff @(posedge aclk) begin
    if (wr_fire && waddr_reg == SQC_BLKCFG_OFF) begin
      blk_sel_mem[blk_idx_reg]  <= wdata_reg[SQC_CFG_SEL];
      blk_mlen_mem[blk_idx_reg] <= wdata_reg[SQC_CFG_MLEN_LO +: SQC_MLEN_W];
      blk_len_mem[blk_idx_reg]  <= wdata_reg[SQC_LEN_W-1:0];
      blk_data_mem[blk_idx_reg] <= blk_data_reg;
    end
  end

  // Read channel; data is sampled when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= SQC_RESP_OKAY;
    end else if (arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rresp_reg   <= known_addr(araddr) ? SQC_RESP_OKAY : SQC_RESP_SLVERR;
      case (araddr)
        SQC_CTRL_OFF:    rdata_reg <= 32'(ctrl_reg);
        SQC_STATUS_OFF:  rdata_reg <= {21'h0, state_reg, in_sync_reg,
                                       seq_active, cur_blk_reg};
        SQC_NBLK_OFF:    rdata_reg <= 32'(nblk_reg);
        SQC_ERRCNT_OFF:  rdata_reg <= err_cnt_reg;
        SQC_BITCNT_OFF:  rdata_reg <= bit_cnt_reg;
        SQC_BWMASK_OFF:  rdata_reg <= bwmask_reg;
        SQC_RTMASK_OFF:  rdata_reg <= rtmask_reg;
        SQC_PATA_LO_OFF: rdata_reg <= pat_reg[0][31:0];
        SQC_PATA_HI_OFF: rdata_reg <= pat_reg[0][63:32];
        SQC_MSKA_LO_OFF: rdata_reg <= msk_reg[0][31:0];
        SQC_MSKA_HI_OFF: rdata_reg <= msk_reg[0][63:32];
        SQC_PATB_LO_OFF: rdata_reg <= pat_reg[1][31:0];
        SQC_PATB_HI_OFF: rdata_reg <= pat_reg[1][63:32];
        SQC_MSKB_LO_OFF: rdata_reg <= msk_reg[1][31:0];
        SQC_MSKB_HI_OFF: rdata_reg <= msk_reg[1][63:32];
        SQC_BLKIDX_OFF:  rdata_reg <= 32'(blk_idx_reg);
        SQC_BLKDATA_OFF: rdata_reg <= blk_data_reg;
        SQC_IRQSTAT_OFF: rdata_reg <= 32'(irq_stat_reg);
        SQC_IRQEN_OFF:   rdata_reg <= 32'(irq_en_reg);
        default:         rdata_reg <= '0;
      endcase
    end else if (rvalid_reg && rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_meta_reg  <= 1'b0;
      rx_sync_reg  <= 1'b0;
      ext_meta_reg <= 1'b0;
      ext_sync_reg <= 1'b0;
    end else begin
      rx_meta_reg  <= rx_data;
      rx_sync_reg  <= rx_meta_reg;
      ext_meta_reg <= ext_mask_in;
      ext_sync_reg <= ext_meta_reg;
    end
  end

  assign rx_bit  = rx_sync_reg ^ ctrl_reg[SQC_C_HIZ];
  assign win_now = {win_reg[SQC_PAT_W-2:0], rx_bit};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      win_reg <= '0;
    end else begin
      win_reg <= win_now;
    end
  end

  assign refused    = ctrl_reg[SQC_C_SEQ_EN] &&
                      (ctrl_reg[SQC_C_MERGE] || ctrl_reg[SQC_C_BURST]);
  assign seq_active = ctrl_reg[SQC_C_SEQ_EN] && !refused;

  assign cur_sel  = blk_sel_mem[cur_blk_reg];
  assign cur_mlen = blk_mlen_mem[cur_blk_reg];
  assign cur_len  = blk_len_mem[cur_blk_reg];

  sqc_match u_match (
    .window   (win_now),
    .pattern  (pat_reg[cur_sel]),
    .mask     (msk_reg[cur_sel]),
    .len_code (cur_mlen),
    .hit      (hit)
  );

  // Route is bit position mod 32
  assign route    = pos_reg[SQC_ROUTE_W-1:0];
  assign route_ok = !(ctrl_reg[SQC_C_RTMASK_EN] && rtmask_reg[route]);
  assign exp_bit  = blk_data_mem[cur_blk_reg][route];

  always_comb begin
    bw_ok = 1'b1;
    if (ctrl_reg[SQC_C_BWIN_EN]) begin
      case (ctrl_reg[SQC_C_KIND_LO +: 2])
        SQC_KIND_PRBS:  bw_ok = 1'b1;
        SQC_KIND_MIXED: bw_ok = !bwmask_reg[cur_blk_reg[SQC_ROUTE_W-1:0]];
        default:        bw_ok = !bwmask_reg[route];
      endcase
    end
  end

  assign ext_hold = ctrl_reg[SQC_C_AUX_EXT] && ctrl_reg[SQC_C_EXT_EN] &&
                    ext_sync_reg;
  assign counted  = (state_reg == SQC_CHECK) && !ext_hold && bw_ok &&
                    route_ok;
  assign bit_err  = counted && (rx_bit != exp_bit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg   <= SQC_IDLE;
      cur_blk_reg <= '0;
      pos_reg     <= '0;
      hunt_reg    <= '0;
      in_sync_reg <= 1'b0;
    end else if (!seq_active) begin
      state_reg   <= SQC_IDLE;
      cur_blk_reg <= '0;
      in_sync_reg <= 1'b0;
    end else begin
      case (state_reg)
        SQC_IDLE: begin
          state_reg   <= SQC_HUNT;
          cur_blk_reg <= '0;
          hunt_reg    <= '0;
        end
        SQC_HUNT: begin
          if (hit) begin
            state_reg   <= SQC_CHECK;
            in_sync_reg <= 1'b1;
            pos_reg     <= SQC_LEN_W'((32'(cur_mlen) + 32'd1)
                                      * SQC_MLEN_STEP);
          end else if (hunt_reg >= cur_len) begin
            // Too long path delay ends here as a lost alignment
            in_sync_reg <= 1'b0;
            cur_blk_reg <= '0;
            hunt_reg    <= '0;
          end else begin
            hunt_reg <= hunt_reg + 1'b1;
          end
        end
        SQC_CHECK: begin
          if (pos_reg + 1'b1 >= cur_len) begin
            state_reg   <= SQC_HUNT;
            hunt_reg    <= '0;
            cur_blk_reg <= (cur_blk_reg + 1'b1 >= nblk_reg) ? '0
                           : cur_blk_reg + 1'b1;
          end else begin
            pos_reg <= pos_reg + 1'b1;
          end
        end
        default: state_reg <= SQC_IDLE;
      endcase
    end
  end

  // Counters restart when sequence mode is left
  always_ff @(posedge aclk) begin
    if (!aresetn || !seq_active) begin
      err_cnt_reg <= '0;
      bit_cnt_reg <= '0;
    end else begin
      if (counted) begin
        bit_cnt_reg <= bit_cnt_reg + 1'b1;
      end
      if (bit_err) begin
        err_cnt_reg <= err_cnt_reg + 1'b1;
      end
    end
  end

  always_comb begin
    irq_evt                = '0;
    irq_evt[SQC_I_SYNC]    = seq_active && state_reg == SQC_HUNT && hit;
    irq_evt[SQC_I_LOSS]    = seq_active && state_reg == SQC_HUNT && !hit &&
                             hunt_reg >= cur_len;
    irq_evt[SQC_I_ERROR]   = bit_err;
    irq_evt[SQC_I_REFUSED] = refused;
  end

  // A new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= '0;
      irq_reg      <= 1'b0;
    end else begin
      if (wr_fire && waddr_reg == SQC_IRQCLR_OFF) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata_reg[SQC_IRQ_W-1:0]) |
                        irq_evt;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_evt;
      end
      irq_reg <= |(irq_stat_reg & irq_en_reg);
    end
  end
endmodule

/* File: sim/sqc_props.sv */
// Bus and status assertions of the sequence checker
`timescale 1ns/1ns
module sqc_props
  import sqc_pkg::*;
(
  input wire logic                  aclk,    // Clock
  input wire logic                  aresetn, // Sync reset, low
  input wire logic                  awvalid, // AW valid
  input wire logic                  awready, // AW ready
  input wire logic                  wvalid,  // W valid
  input wire logic                  wready,  // W ready
  input wire logic [1:0]            bresp,   // B code
  input wire logic                  bvalid,  // B valid
  input wire logic                  bready,  // B ready
  input wire logic [SQC_ADDR_W-1:0] araddr,  // AR address
  input wire logic                  arvalid, // AR valid
  input wire logic                  arready, // AR ready
  input wire logic [31:0]           rdata,   // R data
  input wire logic [1:0]            rresp,   // R code
  input wire logic                  rvalid,  // R valid
  input wire logic                  rready,  // R ready
  input wire logic                  irq,     // Interrupt
  input wire logic                  in_sync  // Aligned
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd; arvalid && arready; endsequence
  sequence s_rd_bad;
    s_rd ##0 (araddr > SQC_IRQCLR_OFF || araddr[1:0] != 2'h0);
  endsequence
  // Reset must be seen even while it is asserted
  property p_rst;
    disable iff (1'b0) !aresetn |=> !bvalid && !rvalid && !irq && !in_sync;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
  property p_b_lat; s_wr |=> !bvalid ##1 bvalid; endproperty
  a_b_lat: assert property (p_b_lat) else $error("write answer late");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_done; bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write not released");
  property p_aw_low; bvalid |-> !awready && !wready; endproperty
  a_aw_low: assert property (p_aw_low) else $error("write taken early");
  property p_r_lat; s_rd |=> rvalid; endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data moved");
  property p_ar_low; rvalid |-> !arready; endproperty
  a_ar_low: assert property (p_ar_low) else $error("read taken early");
  property p_r_bad; s_rd_bad |=> rresp == SQC_RESP_SLVERR && rdata == 32'h0;
  endproperty
  a_r_bad: assert property (p_r_bad) else $error("bad read not refused");
  property p_r_done; rvalid && rready |=> !rvalid && arready; endproperty
  a_r_done: assert property (p_r_done) else $error("read not released");
endmodule

bind sqc_checker sqc_props u_props (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
  .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .irq(irq), .in_sync(in_sync)
);

/* File: sim/sqc_gen.sv */
// Paired pattern generator model driving the serial input
`timescale 1ns/1ns
module sqc_gen #(
  parameter int LEN = 2080
) (
  input  wire logic        aclk,   // Clock
  input  wire logic        run,    // Send blocks
  input  wire logic        inv,    // High level means zero
  input  wire logic        flip,   // Corrupt bit 40 of each block
  input  wire logic [31:0] w0,     // Block 0 word
  input  wire logic [31:0] w1,     // Block 1 word
  output logic             rx_data // Serial line
);
  logic [11:0] pos = 12'h0;
  logic        blk = 1'b0;
  logic        bit_v;
  // same blocks and count as checker
  assign bit_v = (blk ? w1[pos[4:0]] : w0[pos[4:0]]) ^ (flip && pos == 12'd40);
  // block length leaves 2048 bits over the 32-bit match pattern
  always @(posedge aclk) begin
    if (!run || pos == 12'(LEN - 1)) begin
      pos <= 12'h0;
      blk <= run && !blk;
    end else begin
      pos <= pos + 12'h1;
    end
    // Line rests at logic 0 between runs; each run restarts at block 0
    rx_data <= (run && bit_v) ^ inv;
  end
endmodule

/* File: sim/sqc_checker_test.sv */
// Register-level test of the sequence pattern error checker
`timescale 1ns/1ns
module sqc_checker_test;
  import sqc_pkg::*;
  localparam int LEN = 2080;
  localparam logic [31:0] W0 = 32'h3c5a96e1;
  localparam logic [31:0] W1 = 32'h0f712b8d;
  logic aclk = 0, aresetn = 0, ext_mask_in = 0, run = 0, inv = 0, flip = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq, in_sync, rx_data;
  logic [7:0]  awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, resp_v;
  int miscompares = 0, n_tests = 0, cyc = 0;

  sqc_checker dut (.aclk(aclk), .aresetn(aresetn), .rx_data(rx_data),
    .ext_mask_in(ext_mask_in), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq),
    .in_sync(in_sync));
  sqc_gen #(.LEN(LEN)) gen (.aclk(aclk), .run(run), .inv(inv), .flip(flip),
    .w0(W0), .w1(W1), .rx_data(rx_data));

  initial forever #25 aclk = ~aclk;

  task automatic finish_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 95000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp_v = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_v = rdata;
    resp_v = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  function automatic logic [31:0] rev(input logic [31:0] v);
    for (int i = 0; i < 32; i++) rev[i] = v[31-i];
  endfunction

  // Counters clear on leaving sequence mode; the generator restarts at
  // block 0 so the repeating data cannot fake a block start
  task automatic run_cfg(input logic [31:0] c, input logic e, input string nm);
    run <= 1'b0;
    wr(SQC_CTRL_OFF, 32'h0);
    wr(SQC_CTRL_OFF, c);
    run <= 1'b1;
    for (int i = 0; i < 9000 && in_sync !== 1'b1; i++) @(posedge aclk);
    chk("in_sync", {31'h0, in_sync}, 32'h1);
    repeat (2 * LEN + 100) @(posedge aclk);
    rd(SQC_ERRCNT_OFF);
    chk(nm, {31'h0, rd_v != 32'h0}, {31'h0, e});
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(SQC_CTRL_OFF);
    chk("ctrl_reset", rd_v, 32'h0);
    rd(SQC_IRQSTAT_OFF);
    chk("irq_stat_reset", rd_v, 32'h0);
    rd(8'h54);
    chk("unmapped_read", {30'h0, resp_v}, {30'h0, SQC_RESP_SLVERR});
    wr(8'h54, 32'h0);
    chk("unmapped_write", {30'h0, resp_v}, {30'h0, SQC_RESP_SLVERR});
    wr(SQC_ERRCNT_OFF, 32'h5);
    rd(SQC_ERRCNT_OFF);
    chk("errcnt_read_only", rd_v, 32'h0);
    wr(SQC_NBLK_OFF, 32'h2);
    wr(SQC_PATA_LO_OFF, rev(W0));
    // Bit 0 of pattern B is wrong but masked out
    wr(SQC_PATB_LO_OFF, rev(W1) ^ 32'h1);
    wr(SQC_MSKB_LO_OFF, 32'h1);
    for (int b = 0; b < 2; b++) begin
      wr(SQC_BLKIDX_OFF, 32'(b));
      wr(SQC_BLKDATA_OFF, b ? W1 : W0);
      wr(SQC_BLKCFG_OFF, 32'(LEN) | (32'(b) << 16) | (32'h7 << 20));
    end
    wr(SQC_IRQEN_OFF, 32'h1);
    run_cfg(32'h1, 1'b0, "clean_run");
    chk("irq_sync", {31'h0, irq}, 32'h1);
    wr(SQC_IRQEN_OFF, 32'h0);
    @(posedge aclk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    flip <= 1'b1;
    run_cfg(32'h1, 1'b1, "errors_seen");
    wr(SQC_RTMASK_OFF, 32'h100);
    run_cfg(32'h21, 1'b0, "route_mask");
    wr(SQC_BWMASK_OFF, 32'h100);
    run_cfg(32'h11, 1'b0, "bit_mask");
    run_cfg(32'h111, 1'b1, "prbs_no_mask");
    wr(SQC_BWMASK_OFF, 32'h3);
    run_cfg(32'h211, 1'b0, "mixed_mask");
    ext_mask_in <= 1'b1;
    run_cfg(32'h41, 1'b1, "ext_unassigned");
    run_cfg(32'hc1, 1'b0, "ext_masked");
    rd(SQC_BITCNT_OFF);
    chk("ext_bits", rd_v, 32'h0);
    ext_mask_in <= 1'b0;
    flip <= 1'b0;
    inv <= 1'b1;
    run_cfg(32'h3, 1'b0, "polarity");
    wr(SQC_IRQEN_OFF, 32'h8);
    wr(SQC_CTRL_OFF, 32'h5);
    rd(SQC_STATUS_OFF);
    chk("merge_refused", rd_v & 32'h680, 32'h0);
    chk("irq_refused", {31'h0, irq}, 32'h1);
    wr(SQC_CTRL_OFF, 32'h9);
    rd(SQC_STATUS_OFF);
    chk("burst_refused", rd_v & 32'h680, 32'h0);
    wr(SQC_CTRL_OFF, 32'h0);
    wr(SQC_IRQCLR_OFF, 32'h8);
    rd(SQC_IRQSTAT_OFF);
    chk("refused_cleared", rd_v & 32'h8, 32'h0);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    finish_test();
  end
endmodule
